// ==== rtl/tcz_consts.vh ====
// Purpose: Constants for the timer/counter block (offsets, fields, resets).
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Included by the timer/counter design and test files.
`ifndef TCZ_CONSTS_VH
`define TCZ_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TCZ_OFF_CTRL      12'h000
`define TCZ_OFF_CLKCFG    12'h004
`define TCZ_OFF_CNTLO     12'h008
`define TCZ_OFF_CNTHI     12'h00C
`define TCZ_OFF_STATUS    12'h010
`define TCZ_OFF_MASK      12'h014
`define TCZ_OFF_SLEEP     12'h018

// ----------------------------------------------------------------------
// Main control register fields
// ----------------------------------------------------------------------
`define TCZ_CTRL_EN       7
`define TCZ_CTRL_OUT      5
`define TCZ_CTRL_MODE16   4
`define TCZ_CTRL_POST_HI  3
`define TCZ_CTRL_POST_LO  0

// ----------------------------------------------------------------------
// Clock configuration register fields
// ----------------------------------------------------------------------
`define TCZ_CFG_EXT       7
`define TCZ_CFG_ASYNC     4
`define TCZ_CFG_PRE_HI    3
`define TCZ_CFG_PRE_LO    0

// ----------------------------------------------------------------------
// Status / mask bits
// ----------------------------------------------------------------------
`define TCZ_ST_EVENT      0

// ----------------------------------------------------------------------
// Reset values and misc
// ----------------------------------------------------------------------
`define TCZ_RST_CTRL      8'h00
`define TCZ_RST_CLKCFG    8'h00
`define TCZ_RST_CNTLO     8'h00
`define TCZ_RST_CNTHI     8'hFF
`define TCZ_RST_PRE       15'h0000
`define TCZ_RST_POST      4'h0
`define TCZ_MAX_CNT16     16'hFFFF

`endif

// ==== rtl/tcz_prescaler.v ====
// Purpose: Power-of-two prescaler with a free-running synchronous counter.
// Assumes: tick_in is a pclk-domain enable, held high every cycle for the internal source.
// Notes:   The count is not visible to software; clr wipes it.
`timescale 1ns/1ps
`default_nettype none
`include "tcz_consts.vh"

module tcz_prescaler (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clr,
  input  wire       run,
  input  wire [3:0] sel,
  input  wire       tick_in,
  output wire       tick_out
);

  reg  [14:0] pre_q;
  wire [15:0] ext_cnt;

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  // Output fires when the low sel bits of the count are all ones on an input tick;
  // the top guard bit only pads the mask so sel of 15 still spans the whole count
  assign ext_cnt  = {1'b1, pre_q};
  assign tick_out = run & tick_in & (&(ext_cnt | ~((16'h0001 << sel) - 16'h0001))
                    | (sel == 4'h0));

  // Counter clears on clr (low-byte or clock-config writes), otherwise advances per input tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= `TCZ_RST_PRE;
    end else if (clr) begin
      pre_q <= `TCZ_RST_PRE;
    end else if (run && tick_in) begin
      pre_q <= pre_q + 15'h0001;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/tcz_timer.v ====
// Purpose: Timer/counter with prescaler, 8/16-bit count and postscaler, APB slave.
// Assumes: ext_clk_in is synchronous to pclk; sleep_req comes from the power manager.
// Notes:   Registers sit at 32-bit aligned words; upper bits read as zero.
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tcz_consts.vh"

module tcz_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        ext_clk_in,
  input  wire        sleep_req,
  output wire        irq,
  output wire        wake,
  output wire        timer_out,
  output wire        postscaled_event_pulse
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg  [7:0]  main_control_reg_q;
  reg  [7:0]  clock_config_reg_q;
  reg  [7:0]  count_low_byte_q;
  reg  [7:0]  compare_high_byte_q;
  reg  [3:0]  post_q;
  reg         out_level_q;
  reg         event_pulse_q;
  reg         event_irq_flag_q;
  reg         event_irq_enable_q;
  reg         ext_prev_q;
  reg         sleeping_q;
  wire        acc;
  wire        wr;
  wire        wr_ctrl;
  wire        wr_cfg;
  wire        wr_lo;
  wire        wr_hi;
  wire        wr_st;
  wire        wr_mask;
  wire        wr_sleep;
  wire        addr_ok;
  wire        enabled;
  wire        mode16;
  wire        use_ext;
  wire        async_mode;
  wire [3:0]  prescale_select;
  wire [3:0]  postscale_select;
  wire        ext_rise;
  wire        src_tick;
  wire        run;
  wire        pre_tick;
  wire        match8;
  wire        roll16;
  wire        cnt_event;
  wire        post_done;
  wire [15:0] combined_count;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Match the word offset against a known register
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign wr_ctrl  = wr & hit(paddr, `TCZ_OFF_CTRL);
  assign wr_cfg   = wr & hit(paddr, `TCZ_OFF_CLKCFG);
  assign wr_lo    = wr & hit(paddr, `TCZ_OFF_CNTLO);
  assign wr_hi    = wr & hit(paddr, `TCZ_OFF_CNTHI);
  assign wr_st    = wr & hit(paddr, `TCZ_OFF_STATUS);
  assign wr_mask  = wr & hit(paddr, `TCZ_OFF_MASK);
  assign wr_sleep = wr & hit(paddr, `TCZ_OFF_SLEEP);
  assign addr_ok  = hit(paddr, `TCZ_OFF_CTRL) | hit(paddr, `TCZ_OFF_CLKCFG)
                  | hit(paddr, `TCZ_OFF_CNTLO) | hit(paddr, `TCZ_OFF_CNTHI)
                  | hit(paddr, `TCZ_OFF_STATUS) | hit(paddr, `TCZ_OFF_MASK)
                  | hit(paddr, `TCZ_OFF_SLEEP);

  // Zero-wait slave; unmapped accesses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~addr_ok;

  // ----------------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------------
  assign enabled          = main_control_reg_q[`TCZ_CTRL_EN];
  assign mode16           = main_control_reg_q[`TCZ_CTRL_MODE16];
  assign postscale_select = main_control_reg_q[`TCZ_CTRL_POST_HI:`TCZ_CTRL_POST_LO];
  assign use_ext          = clock_config_reg_q[`TCZ_CFG_EXT];
  assign async_mode       = clock_config_reg_q[`TCZ_CFG_ASYNC];
  assign prescale_select  = clock_config_reg_q[`TCZ_CFG_PRE_HI:`TCZ_CFG_PRE_LO];
  assign combined_count   = {compare_high_byte_q, count_low_byte_q};

  // ----------------------------------------------------------------------
  // Clock source and sleep gating
  // ----------------------------------------------------------------------
  // Edge detect the external input; it is a plain synchronous input here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_clk_in;
    end
  end

  assign ext_rise = ext_clk_in & ~ext_prev_q;
  // Internal source ticks every pclk; external ticks per rising edge
  assign src_tick = use_ext ? ext_rise : 1'b1;
  // Sync operation halts in sleep; async keeps running on its input
  assign run      = enabled & (~sleeping_q | async_mode);

  tcz_prescaler u_pre (
    .pclk     (pclk),
    .presetn  (presetn),
    .clr      (wr_lo | wr_cfg),
    .run      (run),
    .sel      (prescale_select),
    .tick_in  (src_tick),
    .tick_out (pre_tick)
  );

  // ----------------------------------------------------------------------
  // Counter and event detection
  // ----------------------------------------------------------------------
  assign match8    = ~mode16 & (count_low_byte_q == compare_high_byte_q);
  assign roll16    = mode16 & (combined_count == `TCZ_MAX_CNT16);
  assign cnt_event = pre_tick & (match8 | roll16);
  assign post_done = cnt_event & (post_q == postscale_select);

  // Count low byte; in 16-bit mode the high byte carries, else it is compare
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_low_byte_q    <= `TCZ_RST_CNTLO;
      compare_high_byte_q <= `TCZ_RST_CNTHI;
    end else begin
      if (wr_lo) begin
        count_low_byte_q <= pwdata[7:0];
      end else if (pre_tick) begin
        if (match8) begin
          count_low_byte_q <= `TCZ_RST_CNTLO;
        end else begin
          count_low_byte_q <= count_low_byte_q + 8'h01;
        end
      end
      if (wr_hi) begin
        compare_high_byte_q <= pwdata[7:0];
      end else if (pre_tick && mode16 && (count_low_byte_q == 8'hFF)) begin
        compare_high_byte_q <= compare_high_byte_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Postscaler and output
  // ----------------------------------------------------------------------
  // Writes to the low byte or main control restart the division
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_q        <= `TCZ_RST_POST;
      event_pulse_q <= 1'b0;
      out_level_q   <= 1'b0;
    end else begin
      event_pulse_q <= post_done;
      if (wr_lo || wr_ctrl) begin
        post_q <= `TCZ_RST_POST;
      end else if (post_done) begin
        post_q <= `TCZ_RST_POST;
      end else if (cnt_event) begin
        post_q <= post_q + 4'h1;
      end
      if (post_done) begin
        out_level_q <= ~out_level_q;
      end
    end
  end

  assign postscaled_event_pulse = event_pulse_q;
  assign timer_out              = out_level_q;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Software writes; the output bit is read-only so it is never stored here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_control_reg_q <= `TCZ_RST_CTRL;
      clock_config_reg_q <= `TCZ_RST_CLKCFG;
      event_irq_enable_q <= 1'b0;
      sleeping_q         <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        main_control_reg_q <= pwdata[7:0] & ~(8'h01 << `TCZ_CTRL_OUT);
      end
      if (wr_cfg) begin
        clock_config_reg_q <= pwdata[7:0];
      end
      if (wr_mask) begin
        event_irq_enable_q <= pwdata[`TCZ_ST_EVENT];
      end
      // Sleep ends on a software clear or on a wake
      if (wr_sleep) begin
        sleeping_q <= pwdata[0];
      end else if (wake) begin
        sleeping_q <= 1'b0;
      end else if (sleep_req) begin
        sleeping_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt flag
  // ----------------------------------------------------------------------
  // A new event wins over a write-one-to-clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_irq_flag_q <= 1'b0;
    end else if (post_done) begin
      event_irq_flag_q <= 1'b1;
    end else if (wr_st && pwdata[`TCZ_ST_EVENT]) begin
      event_irq_flag_q <= 1'b0;
    end
  end

  assign irq  = event_irq_flag_q & event_irq_enable_q;
  assign wake = irq & sleeping_q;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Registered read data, loaded in the setup phase so it is valid at access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `TCZ_OFF_CTRL:   prdata <= {24'h000000, main_control_reg_q
                                    | ({7'h00, out_level_q} << `TCZ_CTRL_OUT)};
        `TCZ_OFF_CLKCFG: prdata <= {24'h000000, clock_config_reg_q};
        `TCZ_OFF_CNTLO:  prdata <= {24'h000000, count_low_byte_q};
        `TCZ_OFF_CNTHI:  prdata <= {24'h000000, compare_high_byte_q};
        `TCZ_OFF_STATUS: prdata <= {31'h00000000, event_irq_flag_q};
        `TCZ_OFF_MASK:   prdata <= {31'h00000000, event_irq_enable_q};
        `TCZ_OFF_SLEEP:  prdata <= {31'h00000000, sleeping_q};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== test/tcz_props.sv ====
// Purpose: Port-level assertions for the timer/counter block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound onto tcz_timer at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "tcz_consts.vh"
module tcz_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        wake,
  input wire logic        timer_out,
  input wire logic        postscaled_event_pulse
);
  wire logic ev = postscaled_event_pulse;
  // Only a flag clear or a mask change may drop the interrupt
  wire logic irq_wr = psel && penable && pwrite
    && (paddr == `TCZ_OFF_STATUS || paddr == `TCZ_OFF_MASK);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_rd;
    psel && penable && !pwrite;
  endsequence
  chk_ready_zero: assert property (s_acc |-> pready)
    else $error("pready low in access phase");
  chk_unmapped_err: assert property (s_acc ##0 paddr > 12'h018 |-> pslverr)
    else $error("no error on unmapped address");
  chk_unmapped_zero: assert property (s_rd ##0 paddr > 12'h018 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_out_readback: assert property (
    s_rd ##0 paddr == `TCZ_OFF_CTRL |-> prdata[`TCZ_CTRL_OUT] == $past(timer_out))
    else $error("output level bit differs from output");
  chk_flag_sticky: assert property (irq && !irq_wr |=> irq)
    else $error("interrupt dropped without software");
  chk_irq_cause: assert property (
    $rose(irq) && !$past(irq_wr) |-> ##[0:1] ev)
    else $error("interrupt rose without event pulse");
  chk_out_toggle: assert property (
    $changed(timer_out) |-> (ev || $past(ev)) or ##1 ev)
    else $error("output toggled without event pulse");
  chk_wake_irq: assert property (wake |-> irq)
    else $error("wake without interrupt");
endmodule
bind tcz_timer tcz_props tcz_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .wake(wake), .timer_out(timer_out),
  .postscaled_event_pulse(postscaled_event_pulse));
`default_nettype wire

// ==== test/tcz_ext_src.sv ====
// Purpose: Model of the external count source feeding the timer.
// Assumes: Edges land on the pclk grid, as the block samples synchronously.
// Notes:   Line rests low between bursts; it never runs free.
`timescale 1ns/1ps
`default_nettype none
module tcz_ext_src (
  input  wire logic pclk,
  output var  logic ext_clk
);
  initial ext_clk = 1'b0;
  // Burst of n rising edges, h pclk cycles per half period
  task automatic run(input int n, input int h);
    repeat (n) begin
      repeat (h) @(posedge pclk);
      ext_clk <= 1'b1;
      repeat (h) @(posedge pclk);
      ext_clk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== test/tb_timer_counter_zero.sv ====
// Purpose: Self-checking bench for the timer/counter block.
// Assumes: Zero-wait APB slave; external input synchronous to pclk.
// Notes:   Random cases come from an LFSR with a fixed start value.
`timescale 1ns/1ps
`default_nettype none
`include "tcz_consts.vh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module tb_timer_counter_zero;
  logic        pclk, presetn, psel, penable, pwrite, sleep_req, ext_clk;
  logic        pready, pslverr, irq, wake, timer_out, pulse, slv, t0, saw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, a, seed;
  int          err_count, compares, n, per, e, c;
  logic [7:0]  rst_t [8] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  cfg_t [3] = '{8'h03, 8'h00, 8'h03};
  logic [7:0]  ctl_t [3] = '{8'h80, 8'h83, 8'h80};
  logic [7:0]  dat_t [3] = '{8'h03, 8'h83, 8'h00};
  logic [11:0] tgt_t [3] = '{`TCZ_OFF_CLKCFG, `TCZ_OFF_CTRL, `TCZ_OFF_CNTLO};
  tcz_timer tcz_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_in(ext_clk), .sleep_req(sleep_req), .irq(irq),
    .wake(wake), .timer_out(timer_out), .postscaled_event_pulse(pulse));
  tcz_ext_src tcz_ext_src_i (.pclk(pclk), .ext_clk(ext_clk));
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One APB transfer; an idle edge first so strobes never change twice in a step
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 50) err_count++;
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rchk(input logic [11:0] ad, input logic [7:0] ex);
    apb(1'b0, ad, 32'h0);
    `CHK("read", ex, rd[7:0])
  endtask
  // Stop, configure, clear counts and flag, then start
  task automatic setup(input logic [7:0] cfg, input logic [7:0] cmp, input logic [7:0] ctl);
    wr(`TCZ_OFF_CTRL, 32'h0);
    wr(`TCZ_OFF_CLKCFG, {24'h0, cfg});
    wr(`TCZ_OFF_CNTHI, {24'h0, cmp});
    wr(`TCZ_OFF_CNTLO, 32'h0);
    wr(`TCZ_OFF_STATUS, 32'h1);
    wr(`TCZ_OFF_CTRL, {24'h0, ctl});
  endtask
  task automatic wait_pulse(output int m);
    m = 1;
    @(negedge pclk);
    while (pulse !== 1'b1 && m < 70000) begin
      @(negedge pclk);
      m++;
    end
  endtask
  // Event spacing in pclk cycles, measured between two event pulses
  task automatic period(input int p, input int cm, input int ps);
    setup({4'h0, p[3:0]}, cm[7:0], {4'h8, ps[3:0]});
    wait_pulse(n);
    t0 = timer_out;
    wait_pulse(per);
    `CHK("period", ((cm + 1) << p) * (ps + 1), per)
    `CHK("toggle", ~t0, timer_out)
  endtask
  task automatic wrap_up();
    $display("Comparisons: %0d, mismatches: %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog sized well above the longest event spacing used
  initial begin
    repeat (95000) @(posedge pclk);
    err_count++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep_req, paddr, pwdata} = '0;
    seed = 32'hEEC0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rchk(12'(i * 4), rst_t[i]);
    end
    `CHK("slverr", 1'b1, slv)
    period(15, 0, 0);
    period(0, 0, 15);
    period(0, 255, 0);
    repeat (4) begin
      seed = lfsr(seed);
      period(seed[1:0], 1 + seed[7:4], seed[9:8]);
    end
    // External edges: prescaled by two, then the 8-bit match
    repeat (2) begin
      seed = lfsr(seed);
      e = 4 + seed[3:0];
      c = 1 + seed[5:4];
      setup(8'h81, c[7:0], 8'h80);
      tcz_ext_src_i.run(e, 2 + seed[7:6]);
      repeat (8) @(posedge pclk);
      rchk(`TCZ_OFF_CNTLO, 8'((e / 2) % (c + 1)));
      rchk(`TCZ_OFF_STATUS, 8'((e / 2) > c));
    end
    // Writes closer than one event keep the hidden counts cleared
    for (int t = 0; t < 3; t++) begin
      setup(cfg_t[t], 8'h00, ctl_t[t]);
      repeat (10) wr(tgt_t[t], {24'h0, dat_t[t]});
      rchk(`TCZ_OFF_STATUS, 8'h00);
    end
    setup(8'h00, 8'hFF, 8'h90);
    wr(`TCZ_OFF_CNTLO, 32'hFD);
    repeat (20) @(posedge pclk);
    rchk(`TCZ_OFF_STATUS, 8'h01);
    rchk(`TCZ_OFF_CNTHI, 8'h00);
    // Sleep: synchronous mode halts, asynchronous keeps counting and wakes
    wr(`TCZ_OFF_MASK, 32'h1);
    for (int m = 0; m < 2; m++) begin
      setup({3'h0, m[0], 4'h0}, 8'hFF, 8'h80);
      sleep_req <= 1'b1;
      apb(1'b0, `TCZ_OFF_CNTLO, 32'h0);
      a = rd;
      repeat (20) @(posedge pclk);
      rchk(`TCZ_OFF_CNTLO, m ? a[7:0] + 8'd23 : a[7:0]);
      saw = 1'b0;
      repeat (300) begin
        @(negedge pclk);
        saw |= wake;
      end
      `CHK("wake", m[0], saw)
      sleep_req <= 1'b0;
      wr(`TCZ_OFF_SLEEP, 32'h0);
    end
    wr(`TCZ_OFF_CTRL, 32'h0);
    @(negedge pclk);
    `CHK("irq", 1'b1, irq)
    wr(`TCZ_OFF_MASK, 32'h0);
    @(negedge pclk);
    `CHK("irq", 1'b0, irq)
    rchk(`TCZ_OFF_STATUS, 8'h01);
    wr(`TCZ_OFF_STATUS, 32'h1);
    rchk(`TCZ_OFF_STATUS, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
